// file: hdl/core_flow_pkg.sv
// package of constants for the core flow and flag unit
package core_flow_pkg;
  // data addresses
  localparam logic [8:0] ADDR_VIRTUAL_INDIRECT = 9'h000;
  localparam logic [8:0] ADDR_FETCH_LOW = 9'h002;
  localparam logic [8:0] ADDR_STATUS = 9'h003;
  localparam logic [8:0] ADDR_INDIRECT_POINTER = 9'h004;
  localparam logic [8:0] ADDR_HIGH_LATCH = 9'h00A;
  localparam logic [8:0] ADDR_EVENT_FLAGS = 9'h00C;
  localparam logic [8:0] ADDR_RESET_CAUSE = 9'h08E;
  // event flag layout
  localparam int FLAG_FIRST_TIMER = 0;
  localparam int FLAG_SECOND_TIMER = 1;
  localparam int FLAG_CAPTURE = 2;
  localparam int FLAG_SERIAL = 3;
  localparam int FLAG_CONVERSION = 6;
  localparam logic [7:0] EVENT_FLAGS_MASK = 8'h4F;
  localparam logic [7:0] EVENT_FLAGS_RESET = 8'h00;
  // reset cause layout
  localparam int CAUSE_BROWNOUT = 0;
  localparam int CAUSE_POWERON = 1;
  localparam logic [7:0] RESET_CAUSE_MASK = 8'h03;
  // status bank bit and interrupt control bit
  localparam int STATUS_BANK_BIT = 7;
  localparam int INTCON_PERIPH_ENABLE = 6;
  // fetch pointer shape
  localparam int FP_WIDTH = 13;
  localparam int JUMP_BITS = 11;
  localparam int LATCH_PAGE_BIT = 3;
  localparam int STACK_DEPTH = 8;
  localparam int STACK_PTR_W = 3;
  localparam logic [12:0] FP_RESET = 13'h0000;
  localparam logic [12:0] FP_STEP = 13'h0001;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] TIMER1_TOP = 16'hFFFF;
  // flow controller states
  typedef enum logic [1:0]
  {
    ST_RUN = 2'b00,
    ST_FLUSH = 2'b01
  } flow_state_t;
endpackage

// file: hdl/core_flow_and_flag_unit.sv
// fetch pointer, return stack, indirect addressing and event flag logic
// Functional notes
// - event flag register at 0Ch, flags clear after reset, software read/write
// - conversion-done flag bit 6 sets on conversion end, stays until cleared
// - bits 7, 5 and 4 of the event flags always read zero
// - bit 0 sets on first-timer 16-bit overflow, stays until cleared
// - brown-out reset clears brown-out flag, power-on flag stays set
// - fetch pointer 13 bits, low byte read/write, top five bits hidden
// - upper fetch bits load from the high-address latch on low-byte writes, calls and jumps, not on returns, interrupt branches or steps
// - eight-entry return stack, outside memory, pointer hidden
// - push on call or interrupt, pop on return, literal return, interrupt exit
// - pushes and pops leave the high-address latch unchanged
// - stack wraps circularly, ninth push overwrites the first, no overflow flag
// - call and jump give 11 bits, latch bits 4 and 3 give the two page bits
// - returns restore all 13 fetch pointer bits from the stack
// - virtual indirect register accesses the register the pointer names
// - indirect read of the virtual register itself returns 00h
// - indirect write of the virtual register itself changes nothing
// - effective address is bank bit then 8-bit pointer, 9 bits
// - event flags set regardless of enables
// - peripheral events request interrupts only with the peripheral enable set
module core_flow_and_flag_unit
  import core_flow_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  input wire logic i_por_event,
  input wire logic i_bor_event,
  // register port
  input wire logic [8:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // instruction controls
  input wire logic i_step,
  input wire logic i_jump,
  input wire logic i_call,
  input wire logic i_ret,
  input wire logic i_irq_branch,
  input wire logic [10:0] i_jump_target,
  input wire logic [12:0] i_irq_vector,
  // peripheral events
  input wire logic i_conversion_done,
  input wire logic i_first_timer_tick,
  input wire logic [15:0] i_first_timer_count,
  input wire logic [7:0] i_second_timer_count,
  input wire logic [7:0] i_second_timer_period,
  input wire logic i_second_timer_tick,
  input wire logic i_serial_event,
  input wire logic i_capture_event,
  input wire logic [7:0] i_peripheral_irq_mask,
  input wire logic [7:0] i_intcon,
  // core-side data memory port for redirected accesses
  output logic [8:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  output logic o_mem_wr,
  output logic o_mem_rd,
  input wire logic [7:0] i_mem_rdata,
  output logic [12:0] o_fetch_pointer,
  output logic [7:0] o_high_address_latch,
  output logic o_peripheral_irq
);

  // ********************************************************************
  // register state
  // ********************************************************************
  // software-visible register images
  logic [7:0] event_flags_q;
  logic [7:0] event_flags_d;
  logic [7:0] reset_cause_q;
  logic [7:0] high_address_latch_q;
  logic [7:0] indirect_pointer_q;
  logic indirect_bank_select_q;
  // fetch pointer and the return stack beside it
  logic [12:0] fetch_pointer_q;
  logic [12:0] fetch_pointer_d;
  logic [12:0] stack_q [STACK_DEPTH];
  logic [STACK_PTR_W-1:0] stack_ptr_q;
  logic [STACK_PTR_W-1:0] stack_top;
  logic [7:0] rdata_q;
  logic redirect_rd_q;
  // decoded access, shared by the read and write paths
  logic [8:0] eff_addr;
  logic direct_indirect;
  logic self_target;
  logic [8:0] tgt_addr;
  logic wr_tgt;
  logic rd_tgt;
  logic push;
  logic pop;
  logic [12:0] jump_full;
  // branch flush tracking
  flow_state_t state_q;

  // ********************************************************************
  // indirect redirection
  // ********************************************************************
  // effective address built from bank bit and pointer; the bank bit selects the upper half of the 9-bit space
  assign eff_addr = {indirect_bank_select_q, indirect_pointer_q};
  assign direct_indirect = (i_addr == ADDR_VIRTUAL_INDIRECT);
  // only bank 0 with pointer 0 aims the virtual register at itself
  assign self_target = direct_indirect && (eff_addr == ADDR_VIRTUAL_INDIRECT);
  // the virtual register holds nothing: every access goes to the pointed register
  assign tgt_addr = direct_indirect ? eff_addr : i_addr;
  // a pointer aimed at itself turns the write into a no-operation
  assign wr_tgt = i_wr && i_clk_en && !self_target;
  assign rd_tgt = i_rd && i_clk_en;

  // local addresses are served here, the rest go out on the memory port
  function automatic logic is_local(input logic [8:0] a);
    case (a)
      ADDR_FETCH_LOW,
      ADDR_STATUS,
      ADDR_INDIRECT_POINTER,
      ADDR_HIGH_LATCH,
      ADDR_EVENT_FLAGS,
      ADDR_RESET_CAUSE: is_local = 1'b1;
      default: is_local = 1'b0;
    endcase
  endfunction

  assign o_mem_addr = tgt_addr;
  assign o_mem_wdata = i_wdata;
  assign o_mem_wr = wr_tgt && !is_local(tgt_addr);
  assign o_mem_rd = rd_tgt && !self_target && !is_local(tgt_addr);

  // ********************************************************************
  // event flags
  // ********************************************************************
  // hardware sets are applied after the software write so a coincident event wins
  always_comb
  begin
    event_flags_d = event_flags_q;
    if (wr_tgt && tgt_addr == ADDR_EVENT_FLAGS)
    begin
      event_flags_d = i_wdata & EVENT_FLAGS_MASK;
    end
    // each source sets its own bit; no enable is consulted here
    if (i_conversion_done)
    begin
      event_flags_d[FLAG_CONVERSION] = 1'b1;
    end
    // overflow is the tick taken while the count stands at its top value
    if (i_first_timer_tick && i_first_timer_count == TIMER1_TOP)
    begin
      event_flags_d[FLAG_FIRST_TIMER] = 1'b1;
    end
    if (i_second_timer_tick && i_second_timer_count == i_second_timer_period)
    begin
      event_flags_d[FLAG_SECOND_TIMER] = 1'b1;
    end
    if (i_serial_event)
    begin
      event_flags_d[FLAG_SERIAL] = 1'b1;
    end
    if (i_capture_event)
    begin
      event_flags_d[FLAG_CAPTURE] = 1'b1;
    end
  end

  // an event arriving while the clock enable is low is lost; sources freeze with the core
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      event_flags_q <= EVENT_FLAGS_RESET;
    end
    else if (i_clk_en)
    begin
      event_flags_q <= event_flags_d;
    end
  end

  // only enabled flags reach the request, and only with the peripheral enable on
  // the global enable is applied where the request is taken, not here
  assign o_peripheral_irq = i_intcon[INTCON_PERIPH_ENABLE] &&
                            |(event_flags_q & i_peripheral_irq_mask & EVENT_FLAGS_MASK);

  // ********************************************************************
  // reset cause flags
  // ********************************************************************
  // power-on leaves the brown-out bit as it was; software must set it first
  // both cause bits are active low and ignore i_nrst, so they survive ordinary resets
  // power-on outranks brown-out when both arrive together
  always_ff @(posedge i_ref_clk)
  begin
    if (i_por_event)
    begin
      reset_cause_q[CAUSE_POWERON] <= 1'b0;
    end
    else if (i_bor_event)
    begin
      reset_cause_q[CAUSE_BROWNOUT] <= 1'b0;
    end
    else if (i_clk_en && wr_tgt && tgt_addr == ADDR_RESET_CAUSE)
    begin
      reset_cause_q <= i_wdata & RESET_CAUSE_MASK;
    end
  end

  // ********************************************************************
  // pointer, status bank bit and high-address latch
  // ********************************************************************
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      indirect_pointer_q <= BYTE_ZERO;
      indirect_bank_select_q <= 1'b0;
      high_address_latch_q <= BYTE_ZERO;
    end
    else if (wr_tgt)
    begin
      if (tgt_addr == ADDR_INDIRECT_POINTER)
      begin
        indirect_pointer_q <= i_wdata;
      end
      // status keeps only the bank bit here; the arithmetic flags live in the execute stage
      if (tgt_addr == ADDR_STATUS)
      begin
        indirect_bank_select_q <= i_wdata[STATUS_BANK_BIT];
      end
      // the latch is touched only by software writes, never by stack traffic
      if (tgt_addr == ADDR_HIGH_LATCH)
      begin
        high_address_latch_q <= i_wdata;
      end
    end
  end

  assign o_high_address_latch = high_address_latch_q;

  // ********************************************************************
  // fetch pointer and return stack
  // ********************************************************************
  assign push = i_call || i_irq_branch;
  // a return in the same cycle as a push is dropped; the push wins
  assign pop = i_ret && !push;
  // the newest entry sits one below the write pointer
  assign stack_top = stack_ptr_q - 3'h1;
  // latch bit 4 fills the thirteenth bit so the target keeps full width
  assign jump_full = {high_address_latch_q[LATCH_PAGE_BIT + 1], high_address_latch_q[LATCH_PAGE_BIT],
                      i_jump_target};

  // priority: interrupt branch, call/jump, return, software low-byte write, step
  always_comb
  begin
    fetch_pointer_d = fetch_pointer_q;
    if (i_irq_branch)
    begin
      // the interrupt vector outranks every instruction control
      fetch_pointer_d = i_irq_vector;
    end
    else if (i_call || i_jump)
    begin
      // call and jump share the page bits from the latch
      fetch_pointer_d = jump_full;
    end
    else if (pop)
    begin
      // a return restores all thirteen bits, so no page fix-up is needed
      fetch_pointer_d = stack_q[stack_top];
    end
    else if (wr_tgt && tgt_addr == ADDR_FETCH_LOW)
    begin
      // writing the low byte loads the hidden upper bits from the latch
      fetch_pointer_d = {high_address_latch_q[FP_WIDTH-9:0], i_wdata};
    end
    else if (i_step)
    begin
      // the ordinary advance to the next instruction word
      fetch_pointer_d = fetch_pointer_q + FP_STEP;
    end
  end

  // a low clock enable holds the pointer like every register except the reset cause bits
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      fetch_pointer_q <= FP_RESET;
    end
    else if (i_clk_en)
    begin
      fetch_pointer_q <= fetch_pointer_d;
    end
  end

  assign o_fetch_pointer = fetch_pointer_q;

  // stack memory is not in any address map; the pointer simply wraps
  // no overflow detection: a ninth push lands on the oldest entry
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      stack_ptr_q <= '0;
    end
    else if (i_clk_en)
    begin
      if (push)
      begin
        stack_q[stack_ptr_q] <= i_irq_branch ? fetch_pointer_q : fetch_pointer_q + FP_STEP;
        stack_ptr_q <= stack_ptr_q + 3'h1;
      end
      else if (pop)
      begin
        stack_ptr_q <= stack_top;
      end
    end
  end

  // flush state marks the cycle after a branch; branches cost two cycles
  // the two unused codes of the state word fall back to the run state
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      state_q <= ST_RUN;
    end
    else if (i_clk_en)
    begin
      unique case (state_q)
        ST_RUN: state_q <= (push || pop || i_jump) ? ST_FLUSH : ST_RUN;
        ST_FLUSH: state_q <= ST_RUN;
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // ********************************************************************
  // read data
  // ********************************************************************
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      rdata_q <= BYTE_ZERO;
      redirect_rd_q <= 1'b0;
    end
    else if (i_clk_en)
    begin
      redirect_rd_q <= o_mem_rd;
      rdata_q <= BYTE_ZERO;
      if (rd_tgt && self_target)
      begin
        rdata_q <= BYTE_ZERO;
      end
      else if (rd_tgt)
      begin
        // addresses not served here fall through to the memory port
        case (tgt_addr)
          ADDR_EVENT_FLAGS: rdata_q <= event_flags_q & EVENT_FLAGS_MASK;
          ADDR_RESET_CAUSE: rdata_q <= reset_cause_q & RESET_CAUSE_MASK;
          ADDR_FETCH_LOW: rdata_q <= fetch_pointer_q[7:0];
          ADDR_INDIRECT_POINTER: rdata_q <= indirect_pointer_q;
          ADDR_HIGH_LATCH: rdata_q <= high_address_latch_q;
          ADDR_STATUS: rdata_q <= {indirect_bank_select_q, 7'h00};
          default: rdata_q <= BYTE_ZERO;
        endcase
      end
    end
  end

  // external memory answers in the following cycle, muxed here
  // local read data fall back to zero after their one cycle so no stale byte lingers
  assign o_rdata = redirect_rd_q ? i_mem_rdata : rdata_q;

endmodule

// file: tb/mem_model.sv
// data memory standing behind the redirected access port
module mem_model
(
  input wire logic i_ref_clk,
  input wire logic [8:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [512];
  // known fill so that redirected reads can be predicted
  initial
  begin
    o_rdata = 8'h00;
    for (int i = 0; i < 512; i++)
    begin
      mem[i] = 8'(i) ^ 8'hA5;
    end
  end
  // answer one cycle after a read; idle cycles invert so no stale byte looks valid
  always @(posedge i_ref_clk)
  begin
    if (i_wr)
    begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= i_rd ? mem[i_addr] : ~o_rdata;
  end
endmodule

// file: tb/core_flow_chk.sv
// port-level assertions for the core flow and flag unit
module core_flow_chk
  import core_flow_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  input wire logic [8:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_step,
  input wire logic i_jump,
  input wire logic i_call,
  input wire logic i_ret,
  input wire logic i_irq_branch,
  input wire logic [10:0] i_jump_target,
  input wire logic i_conversion_done,
  input wire logic [7:0] i_peripheral_irq_mask,
  input wire logic [7:0] i_intcon,
  input wire logic [8:0] o_mem_addr,
  input wire logic [7:0] o_mem_wdata,
  input wire logic o_mem_wr,
  input wire logic [12:0] o_fetch_pointer,
  input wire logic [7:0] o_high_address_latch,
  input wire logic o_peripheral_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // one clock domain, so defaults are set once
  // ****************************************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);
  reserved_bits_a: assert property (i_clk_en && i_rd && i_addr == ADDR_EVENT_FLAGS |=>
    (o_rdata & ~EVENT_FLAGS_MASK) == BYTE_ZERO) else $error("reserved flag bits read nonzero");
  conv_flag_a: assert property (i_clk_en && i_conversion_done && i_intcon[6] && i_peripheral_irq_mask[6] |=>
    o_peripheral_irq) else $error("conversion flag not raised");
  irq_gate_a: assert property (!i_intcon[INTCON_PERIPH_ENABLE] |-> !o_peripheral_irq)
    else $error("peripheral request without enable");
  call_page_a: assert property (i_clk_en && i_call && !i_irq_branch |=> o_fetch_pointer ==
    {$past(o_high_address_latch[4:3]), $past(i_jump_target)}) else $error("call target wrong");
  jump_page_a: assert property (i_clk_en && i_jump && !i_call && !i_ret && !i_irq_branch |=>
    o_fetch_pointer[12:11] == $past(o_high_address_latch[4:3])) else $error("jump page bits wrong");
  latch_kept_a: assert property (i_clk_en && (i_call || i_ret) && !i_wr |=>
    $stable(o_high_address_latch)) else $error("latch moved by stack");
  step_inc_a: assert property (i_clk_en && i_step && !(i_jump || i_call || i_ret || i_irq_branch || i_wr)
    |=> o_fetch_pointer == $past(o_fetch_pointer) + FP_STEP) else $error("step did not advance");
  self_write_a: assert property (i_wr && i_addr == ADDR_VIRTUAL_INDIRECT |->
    !(o_mem_wr && o_mem_addr == ADDR_VIRTUAL_INDIRECT)) else $error("indirect self write reached memory");
  redirect_data_a: assert property (i_clk_en && i_wr && i_addr != ADDR_VIRTUAL_INDIRECT && o_mem_wr |->
    o_mem_addr == i_addr && o_mem_wdata == i_wdata) else $error("direct write address or data wrong");
endmodule
bind core_flow_and_flag_unit core_flow_chk chk_u (.i_ref_clk, .i_nrst, .i_clk_en, .i_addr, .i_wdata, .i_wr,
  .i_rd, .o_rdata, .i_step, .i_jump, .i_call, .i_ret, .i_irq_branch, .i_jump_target, .i_conversion_done,
  .i_peripheral_irq_mask, .i_intcon, .o_mem_addr, .o_mem_wdata, .o_mem_wr, .o_fetch_pointer,
  .o_high_address_latch, .o_peripheral_irq);

// file: tb/tb_core_flow_and_flag_unit.sv
// self-checking bench for the core flow and flag unit
module tb_core_flow_and_flag_unit import core_flow_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = 1'b0, i_nrst = 1'b0, i_clk_en = 1'b1, i_por_event = 1'b0, i_bor_event = 1'b0;
  logic i_wr = 1'b0, i_rd = 1'b0, i_step, i_jump, i_call, i_ret, i_irq_branch, o_peripheral_irq;
  logic i_conversion_done, i_first_timer_tick, i_second_timer_tick, i_serial_event, i_capture_event;
  logic o_mem_wr, o_mem_rd;
  logic [8:0] i_addr = 9'h000, o_mem_addr;
  logic [7:0] i_wdata = 8'h00, i_second_timer_count = 8'h00, i_second_timer_period = 8'h10;
  logic [7:0] i_peripheral_irq_mask = 8'hFF, i_intcon = 8'h00, o_rdata, o_mem_wdata, i_mem_rdata, o_high_address_latch;
  logic [15:0] i_first_timer_count = 16'hFFFE;
  logic [10:0] i_jump_target = 11'h123;
  logic [12:0] i_irq_vector = 13'h0004, o_fetch_pointer;
  logic [4:0] ctl = 5'h00, ev = 5'h00;
  int miscompares = 0, checked = 0, cycles = 0;
  assign {i_irq_branch, i_ret, i_call, i_jump, i_step} = ctl;
  assign {i_capture_event, i_serial_event, i_second_timer_tick, i_first_timer_tick, i_conversion_done} = ev;
  core_flow_and_flag_unit dut_u (.i_ref_clk, .i_nrst, .i_clk_en, .i_por_event, .i_bor_event, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .i_step, .i_jump, .i_call, .i_ret, .i_irq_branch, .i_jump_target, .i_irq_vector,
    .i_conversion_done, .i_first_timer_tick, .i_first_timer_count, .i_second_timer_count, .i_second_timer_period,
    .i_second_timer_tick, .i_serial_event, .i_capture_event, .i_peripheral_irq_mask, .i_intcon, .o_mem_addr,
    .o_mem_wdata, .o_mem_wr, .o_mem_rd, .i_mem_rdata, .o_fetch_pointer, .o_high_address_latch, .o_peripheral_irq);
  mem_model mem_u (.i_ref_clk, .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_wr(o_mem_wr), .i_rd(o_mem_rd),
    .o_rdata(i_mem_rdata));
  // ****************************************
  // clock, watchdog and shared tasks
  // ****************************************
  always #2.5 i_ref_clk = ~i_ref_clk;
  // the full sequence needs well under a thousand cycles
  always @(posedge i_ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      miscompares = miscompares + 1;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 chk(13'(o_rdata), 13'(e));
  endtask
  // one-cycle instruction pulses and peripheral events
  task automatic go(input logic [4:0] c, input logic [4:0] e);
    @(posedge i_ref_clk);
    ctl <= c;
    ev <= e;
    @(posedge i_ref_clk);
    ctl <= 5'h00;
    ev <= 5'h00;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (20) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    rd(ADDR_EVENT_FLAGS, 8'h00);
    go(5'h00, 5'h06);
    rd(ADDR_EVENT_FLAGS, 8'h00);
    wr(ADDR_EVENT_FLAGS, 8'hFF);
    rd(ADDR_EVENT_FLAGS, EVENT_FLAGS_MASK);
    wr(ADDR_EVENT_FLAGS, 8'h00);
    i_first_timer_count <= 16'hFFFF;
    i_second_timer_count <= 8'h10;
    go(5'h00, 5'h1F);
    rd(ADDR_EVENT_FLAGS, EVENT_FLAGS_MASK);
    chk(13'(o_peripheral_irq), 13'h0000);
    wr(ADDR_HIGH_LATCH, 8'h18);
    i_intcon <= 8'h40;
    go(5'h00, 5'h01);
    wr(ADDR_FETCH_LOW, 8'h34);
    #1 chk(13'(o_peripheral_irq), 13'h0001);
    chk(o_fetch_pointer, 13'h1834);
    rd(ADDR_FETCH_LOW, 8'h34);
    go(5'h01, 5'h00);
    #1 chk(o_fetch_pointer, 13'h1835);
    go(5'h04, 5'h00);
    #1 chk(o_fetch_pointer, 13'h1923);
    go(5'h08, 5'h00);
    #1 chk(o_fetch_pointer, 13'h1836);
    chk(13'(o_high_address_latch), 13'h0018);
    go(5'h10, 5'h00);
    #1 chk(o_fetch_pointer, 13'h0004);
    go(5'h08, 5'h00);
    #1 chk(o_fetch_pointer, 13'h1836);
    wr(ADDR_HIGH_LATCH, 8'h08);
    i_jump_target <= 11'h7FF;
    go(5'h02, 5'h00);
    i_clk_en <= 1'b0;
    #1 chk(o_fetch_pointer, 13'h0FFF);
    go(5'h01, 5'h00);
    #1 chk(o_fetch_pointer, 13'h0FFF);
    @(posedge i_ref_clk) i_clk_en <= 1'b1;
    wr(ADDR_HIGH_LATCH, 8'h00);
    wr(ADDR_FETCH_LOW, 8'h00);
    // nine calls into an eight-deep stack, then nine returns
    for (int k = 1; k <= 9; k++)
    begin
      i_jump_target <= 11'(k);
      go(5'h04, 5'h00);
    end
    for (int k = 9; k >= 1; k--)
    begin
      go(5'h08, 5'h00);
      #1 chk(o_fetch_pointer, 13'(k > 1 ? k : 9));
    end
    wr(ADDR_INDIRECT_POINTER, 8'h20);
    wr(ADDR_VIRTUAL_INDIRECT, 8'h5A);
    rd(ADDR_VIRTUAL_INDIRECT, 8'h5A);
    wr(ADDR_STATUS, 8'h80);
    rd(ADDR_VIRTUAL_INDIRECT, 8'h85);
    wr(ADDR_STATUS, 8'h00);
    wr(ADDR_INDIRECT_POINTER, 8'h00);
    wr(ADDR_VIRTUAL_INDIRECT, 8'h77);
    rd(ADDR_VIRTUAL_INDIRECT, 8'h00);
    chk(13'(mem_u.mem[0]), 13'h00A5);
    rd(9'h050, 8'hF5);
    // a clear meeting an event in the same cycle loses to the event
    @(posedge i_ref_clk) ev <= 5'h01;
    wr(ADDR_EVENT_FLAGS, 8'h00);
    ev <= 5'h00;
    rd(ADDR_EVENT_FLAGS, 8'h40);
    // a masked flag must not reach the request
    @(posedge i_ref_clk) i_peripheral_irq_mask <= 8'hBF;
    @(posedge i_ref_clk) #1 chk(13'(o_peripheral_irq), 13'h0000);
    @(posedge i_ref_clk) i_por_event <= 1'b1;
    @(posedge i_ref_clk) i_por_event <= 1'b0;
    wr(ADDR_RESET_CAUSE, 8'h03);
    rd(ADDR_RESET_CAUSE, 8'h03);
    @(posedge i_ref_clk) i_bor_event <= 1'b1;
    @(posedge i_ref_clk) i_bor_event <= 1'b0;
    rd(ADDR_RESET_CAUSE, 8'h02);
    close_out();
  end
endmodule
